// *** lwc_pkg.sv ***
package lwc_pkg;

	localparam int          GND_COUNT          = 14;
	localparam int          PROG_COUNT         = 8;
	localparam int          FRAME_BITS         = 32;
	localparam int          DATA_BITS          = 24;
	localparam int          REPLY_FAULT_BIT    = 23;
	localparam int          REPLY_INT_BIT      = 22;
	localparam int          REPLY_DATA_BITS    = 22;
	localparam int          REPLY_PAD_BITS     = FRAME_BITS - DATA_BITS;

	localparam logic [6:0]  ADDR_COMP_ONLY_GND = 7'h13;
	localparam logic [6:0]  ADDR_THR_PROG      = 7'h14;
	localparam logic [6:0]  ADDR_THR_GND       = 7'h15;
	localparam logic        WRITE_FLAG         = 1'b1;

	localparam logic [23:0] RST_COMP_ONLY_GND  = 24'h000000;
	localparam logic [23:0] RST_THR_PROG       = 24'h000000;
	localparam logic [23:0] RST_THR_GND        = 24'h000000;

	localparam logic [5:0]  BIT_CNT_FULL       = 6'h20;
	localparam logic [5:0]  BIT_CNT_LAST       = 6'h1f;

	typedef struct packed {
		logic [6:0]  addr;
		logic        write;
		logic [23:0] data;
	} lwc_frame_t;

	typedef struct packed {
		logic [5:0]  bitCnt;
		logic        done;
		logic [31:0] shiftIn;
		logic [31:0] shiftOut;
	} lwc_link_t;

	typedef struct packed {
		logic [GND_COUNT-1:0]  compOnlyGnd;
		logic [PROG_COUNT-1:0] thrProg;
		logic [GND_COUNT-1:0]  thrGnd;
		logic                  doneSeen;
		logic [DATA_BITS-1:0]  replyData;
		logic [GND_COUNT-1:0]  lastSample;
		logic                  baselineValid;
		logic                  wakeReq;
		logic [GND_COUNT-1:0]  gndCompOnlyActive;
		logic [GND_COUNT-1:0]  gndNormThr;
		logic [PROG_COUNT-1:0] progNormThr;
	} lwc_core_t;

	localparam lwc_core_t CORE_RESET = '{
		compOnlyGnd: RST_COMP_ONLY_GND[GND_COUNT-1:0],
		thrProg:     RST_THR_PROG[PROG_COUNT-1:0],
		thrGnd:      RST_THR_GND[GND_COUNT-1:0],
		default:     '0
	};

endpackage : lwc_pkg

// *** lwc_sync2.sv ***
`timescale 1ns/10ps
module lwc_sync2
	import lwc_pkg::*;
#(
	parameter int WIDTH = 1
)(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Crossing
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} lwc_sync_t;

	lwc_sync_t syncReg;
	lwc_sync_t syncNext;

	always_comb
	begin
		syncNext        = syncReg;
		syncNext.stage1 = asyncIn;
		syncNext.stage2 = syncReg.stage1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			syncReg <= '0;
		else
			syncReg <= syncNext;
	end

	assign syncOut = syncReg.stage2;

endmodule : lwc_sync2

// *** lwc_wake_config_regs.sv ***
`timescale 1ns/10ps
module lwc_wake_config_regs
	import lwc_pkg::*;
(
	// Core clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Serial link
	input  wire logic                  sclk,
	input  wire logic                  cs_n,
	input  wire logic                  mosi,
	output logic                       miso,
	// Device status for replies
	input  wire logic                  faultSummary,
	input  wire logic                  interruptFlagBit,
	// Sleep control
	input  wire logic                  sleepState,
	input  wire logic                  sleepTick,
	input  wire logic [PROG_COUNT-1:0] progToBattery,
	input  wire logic [GND_COUNT-1:0]  groundSwitchInputLevel,
	// Sleep configuration outputs
	output logic      [GND_COUNT-1:0]  gndCompOnlyActive,
	output logic      [GND_COUNT-1:0]  groundUseNormalInputThreshold,
	output logic      [PROG_COUNT-1:0] progUseNormalInputThreshold,
	output logic                       wakeRequest
);

	lwc_link_t            linkReg;
	lwc_link_t            linkNext;
	lwc_core_t            coreReg;
	lwc_core_t            coreNext;
	logic                 doneSync;
	logic [GND_COUNT-1:0] gndLevelSync;
	lwc_frame_t           frameNow;
	logic                 frameEvent;

	// Link side: shift in the command, shift out the previous reply
	always_comb
	begin
		linkNext = linkReg;
		if (linkReg.bitCnt != BIT_CNT_FULL)
		begin
			linkNext.bitCnt  = linkReg.bitCnt + 6'h01;
			linkNext.shiftIn = {linkReg.shiftIn[FRAME_BITS-2:0], mosi};
		end
		linkNext.done = linkReg.done | (linkReg.bitCnt == BIT_CNT_LAST);
		// Reply word is held still between frames, so it is safe to load here
		if (linkReg.bitCnt == 6'h00)
			linkNext.shiftOut = {{REPLY_PAD_BITS{1'b0}}, coreReg.replyData};
		else
			linkNext.shiftOut = {linkReg.shiftOut[FRAME_BITS-2:0], 1'b0};
	end

	// Deselect ends the frame even when the link clock has stopped
	always_ff @(posedge sclk or posedge cs_n)
	begin
		if (cs_n)
			linkReg <= '0;
		else
			linkReg <= linkNext;
	end

	// Reply bits change on the falling edge, host samples on the rising one
	always_ff @(negedge sclk or posedge cs_n)
	begin
		if (cs_n)
			miso <= 1'b0;
		else
			miso <= linkReg.shiftOut[FRAME_BITS-2];
	end

	lwc_sync2 #(
		.WIDTH   (1)
	) frameDoneSync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn (linkReg.done),
		.syncOut (doneSync)
	);

	lwc_sync2 #(
		.WIDTH   (GND_COUNT)
	) groundLevelSync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn (groundSwitchInputLevel),
		.syncOut (gndLevelSync)
	);

	// Frame word is stable while the done level is high
	assign frameNow   = lwc_frame_t'(linkReg.shiftIn);
	assign frameEvent = doneSync & ~coreReg.doneSeen;

	// Core side: register file, reply, sleep behaviour
	always_comb
	begin
		coreNext          = coreReg;
		coreNext.doneSeen = doneSync;
		coreNext.wakeReq  = 1'b0;
		if (frameEvent && frameNow.write == WRITE_FLAG)
		begin
			case (frameNow.addr)
				ADDR_COMP_ONLY_GND: coreNext.compOnlyGnd = frameNow.data[GND_COUNT-1:0];
				ADDR_THR_PROG:      coreNext.thrProg     = frameNow.data[PROG_COUNT-1:0];
				ADDR_THR_GND:       coreNext.thrGnd      = frameNow.data[GND_COUNT-1:0];
				default:            ;
			endcase
		end
		if (frameEvent)
		begin
			coreNext.replyData                  = '0;
			coreNext.replyData[REPLY_FAULT_BIT] = faultSummary;
			coreNext.replyData[REPLY_INT_BIT]   = interruptFlagBit;
			case (frameNow.addr)
				ADDR_COMP_ONLY_GND: coreNext.replyData[GND_COUNT-1:0]  = coreNext.compOnlyGnd;
				ADDR_THR_PROG:      coreNext.replyData[PROG_COUNT-1:0] = coreNext.thrProg;
				ADDR_THR_GND:       coreNext.replyData[GND_COUNT-1:0]  = coreNext.thrGnd;
				default:            ;
			endcase
		end
		// Comparator-only inputs: compare each sleep tick after the first in a sleep against the last sample
		if (!sleepState)
			coreNext.baselineValid = 1'b0;
		else if (sleepTick)
		begin
			coreNext.lastSample    = gndLevelSync;
			coreNext.baselineValid = 1'b1;
			coreNext.wakeReq       = coreReg.baselineValid &
				(|(coreReg.compOnlyGnd & (gndLevelSync ^ coreReg.lastSample)));
		end
		coreNext.gndCompOnlyActive = sleepState ? coreReg.compOnlyGnd : '0;
		coreNext.gndNormThr        = coreReg.thrGnd;
		coreNext.progNormThr       = coreReg.thrProg | progToBattery;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			coreReg <= CORE_RESET;
		else
			coreReg <= coreNext;
	end

	assign gndCompOnlyActive             = coreReg.gndCompOnlyActive;
	assign groundUseNormalInputThreshold = coreReg.gndNormThr;
	assign progUseNormalInputThreshold   = coreReg.progNormThr;
	assign wakeRequest                   = coreReg.wakeReq;

	// Checks on the core domain
	a_write_comp_only: assert property (
		@(posedge clk) disable iff (!rst_n)
		frameEvent && frameNow.write && frameNow.addr == ADDR_COMP_ONLY_GND
		|=> coreReg.compOnlyGnd == $past(frameNow.data[GND_COUNT-1:0]))
		else $error("comparator-only write not stored");

	a_write_thr_prog: assert property (
		@(posedge clk) disable iff (!rst_n)
		frameEvent && frameNow.write && frameNow.addr == ADDR_THR_PROG
		|=> coreReg.thrProg == $past(frameNow.data[PROG_COUNT-1:0]))
		else $error("programmable threshold write not stored");

	a_write_thr_gnd: assert property (
		@(posedge clk) disable iff (!rst_n)
		frameEvent && frameNow.write && frameNow.addr == ADDR_THR_GND
		|=> ##1 groundUseNormalInputThreshold == $past(frameNow.data[GND_COUNT-1:0], 2))
		else $error("ground threshold write not reaching output");

	a_reply_flags: assert property (
		@(posedge clk) disable iff (!rst_n)
		frameEvent |=> coreReg.replyData[REPLY_FAULT_BIT] == $past(faultSummary)
			&& coreReg.replyData[REPLY_INT_BIT] == $past(interruptFlagBit))
		else $error("reply flags wrong");

	a_reply_data: assert property (
		@(posedge clk) disable iff (!rst_n)
		frameEvent && frameNow.addr == ADDR_THR_PROG
		|=> coreReg.replyData[REPLY_DATA_BITS-1:0] == {14'h0000, coreReg.thrProg})
		else $error("reply data differs from register");

	a_read_no_change: assert property (
		@(posedge clk) disable iff (!rst_n)
		frameEvent && !frameNow.write |=> $stable(coreReg.compOnlyGnd)
			&& $stable(coreReg.thrProg) && $stable(coreReg.thrGnd))
		else $error("read changed a register");

	a_comp_only_out: assert property (
		@(posedge clk) disable iff (!rst_n)
		sleepState |=> gndCompOnlyActive == $past(coreReg.compOnlyGnd))
		else $error("comparator-only output wrong in sleep");

	a_awake_no_comp: assert property (
		@(posedge clk) disable iff (!rst_n)
		!sleepState |=> gndCompOnlyActive == '0)
		else $error("comparator-only active while awake");

	// A tick right after the waking one may legally raise a second pulse
	a_wake_on_change: assert property (
		@(posedge clk) disable iff (!rst_n)
		sleepState && sleepTick && coreReg.baselineValid
			&& |(coreReg.compOnlyGnd & (gndLevelSync ^ coreReg.lastSample))
		|=> wakeRequest ##1 (!wakeRequest || $past(sleepTick)))
		else $error("missed wake on level change");

	a_no_wake_awake: assert property (
		@(posedge clk) disable iff (!rst_n)
		!sleepState |=> !wakeRequest)
		else $error("wake requested while awake");

	a_battery_thr: assert property (
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> (progUseNormalInputThreshold & $past(progToBattery)) == $past(progToBattery))
		else $error("battery input not on normal threshold");

	a_prog_thr: assert property (
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> progUseNormalInputThreshold == $past(coreReg.thrProg | progToBattery))
		else $error("programmable threshold select wrong");

	// Link side: done must stand exactly from the 32nd bit on, seen at each falling edge
	a_frame_done: assert property (
		@(negedge sclk) disable iff (cs_n)
		linkReg.done == (linkReg.bitCnt == BIT_CNT_FULL))
		else $error("frame end not flagged at bit 32");

	c_write_comp_only: cover property (@(posedge clk) disable iff (!rst_n)
		frameEvent && frameNow.write && frameNow.addr == ADDR_COMP_ONLY_GND);
	c_read_thr_gnd: cover property (@(posedge clk) disable iff (!rst_n)
		frameEvent && !frameNow.write && frameNow.addr == ADDR_THR_GND);
	c_wake: cover property (@(posedge clk) disable iff (!rst_n)
		sleepState ##[1:200] wakeRequest);
	c_battery_override: cover property (@(posedge clk) disable iff (!rst_n)
		sleepState && (progToBattery & ~coreReg.thrProg) != '0);

endmodule : lwc_wake_config_regs

// *** lwc_spi_host.sv ***
`timescale 1ns/10ps
module lwc_spi_host
(
	// Serial link
	output logic      sclk,
	output logic      csN,
	output logic      mosi,
	input  wire logic miso
);
	initial
	begin
		sclk = 1'b0;
		csN  = 1'b1;
		mosi = 1'b1;
	end

	// Mode 0, MSB first; the clock stands still outside frames
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		#3.3 csN = 1'b0;
		for (int k = 31; k >= 0; k--)
		begin
			mosi = tx[k];
			#7.5 sclk = 1'b1;
			rx[k] = miso;
			#7.5 sclk = 1'b0;
		end
		#40 csN = 1'b1;
		mosi = ~mosi;
		#60;
	endtask : xfer
endmodule : lwc_spi_host

// *** lwc_wake_config_regs_tb_top.sv ***
`timescale 1ns/10ps
module lwc_wake_config_regs_tb_top;
	import lwc_pkg::*;
	logic                  clk, rst_n, fault, intf, sleep, tick, wake, miso, sclk, csN, mosi;
	logic [PROG_COUNT-1:0] toBat, progNorm;
	logic [GND_COUNT-1:0]  pins, compAct, gndNorm;
	logic [31:0]           seed, expReply;
	logic [23:0]           model [128];
	int                    miscompares, totalChecks;

	lwc_spi_host host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));
	lwc_wake_config_regs DUT (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(csN),
		.mosi(mosi), .miso(miso), .faultSummary(fault), .interruptFlagBit(intf),
		.sleepState(sleep), .sleepTick(tick), .progToBattery(toBat),
		.groundSwitchInputLevel(pins), .gndCompOnlyActive(compAct),
		.groundUseNormalInputThreshold(gndNorm), .progUseNormalInputThreshold(progNorm),
		.wakeRequest(wake));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [23:0] maskOf(input logic [6:0] a);
		case (a)
			ADDR_COMP_ONLY_GND, ADDR_THR_GND: return 24'h003fff;
			ADDR_THR_PROG: return 24'h0000ff;
			default: return 24'h000000;
		endcase
	endfunction : maskOf

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic results;
		if (miscompares == 0 && totalChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	// Reply to a frame arrives during the next one
	task automatic frame(input logic [6:0] a, input logic w, input logic [23:0] d);
		logic [31:0] rx;
		host.xfer({a, w, d}, rx);
		check(rx, expReply);
		if (w)
			model[a] = d & maskOf(a);
		expReply = {8'h00, fault, intf, model[a][21:0]};
	endtask : frame

	task automatic checkOuts;
		repeat (6) @(posedge clk);
		#1;
		check(32'(gndNorm), 32'(model[ADDR_THR_GND]));
		check(32'(progNorm), 32'(model[ADDR_THR_PROG] | 24'(toBat)));
		check(32'(compAct), sleep ? 32'(model[ADDR_COMP_ONLY_GND]) : 32'h0);
	endtask : checkOuts

	task automatic tickCheck(input logic expWake);
		@(posedge clk) tick <= 1'b1;
		@(posedge clk) tick <= 1'b0;
		#1 check(32'(wake), 32'(expWake));
		@(posedge clk) #1 check(32'(wake), 32'h0);
	endtask : tickCheck

	task automatic toggle(input int i);
		@(posedge clk) pins[i] <= ~pins[i];
		repeat (4) @(posedge clk);
	endtask : toggle

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial
	begin
		#200000;
		miscompares++;
		results;
	end

	initial
	begin
		{rst_n, fault, intf, sleep, tick, toBat, pins} = '0;
		seed = 32'h14ad9b44;
		expReply = 32'h0;
		foreach (model[i])
			model[i] = 24'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		frame(ADDR_COMP_ONLY_GND, 1'b0, 24'hffffff);
		frame(ADDR_THR_PROG, 1'b0, 24'hffffff);
		frame(ADDR_THR_GND, 1'b0, 24'hffffff);
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clk);
			fault <= rnd() & 1;
			intf <= rnd() & 1;
			sleep <= rnd() & 1;
			toBat <= PROG_COUNT'(rnd());
			frame(ADDR_COMP_ONLY_GND + 7'(rnd() & 3), rnd() & 1, 24'(rnd()));
			checkOuts;
		end
		frame(ADDR_THR_PROG, 1'b1, 24'hffffa5);
		frame(ADDR_THR_GND, 1'b1, 24'hffc3a5);
		frame(ADDR_COMP_ONLY_GND, 1'b1, 24'h000005);
		@(posedge clk) sleep <= 1'b0;
		toggle(0);
		tickCheck(1'b0);
		@(posedge clk) sleep <= 1'b1;
		checkOuts;
		tickCheck(1'b0);
		toggle(1);
		tickCheck(1'b0);
		toggle(2);
		tickCheck(1'b1);
		frame(ADDR_THR_GND, 1'b0, 24'h0);
		results;
	end
endmodule : lwc_wake_config_regs_tb_top
